// ### logic/mtd_defs.vh
/*
 File: constants for the measurement trigger detector: register offsets,
 field positions, reset values, slope and source codes.
 Assumes: included by bare name from the design files of this block.
*/
`ifndef MTD_DEFS_VH
`define MTD_DEFS_VH

// ==========================================================
// Register word indices (AXI byte address bits 5:2)
`define MTD_OFF_CTRL        4'h0
`define MTD_OFF_CURR_LEVEL  4'h1
`define MTD_OFF_CURR_HYST   4'h2
`define MTD_OFF_VOLT_LEVEL  4'h3
`define MTD_OFF_VOLT_HYST   4'h4
`define MTD_OFF_COUNT       4'h5
`define MTD_OFF_STATUS      4'h6
`define MTD_OFF_CMD         4'h7
`define MTD_OFF_SEQ_DEF     4'h8

// ==========================================================
// Control register fields
`define MTD_CTRL_SRC_BIT    0
`define MTD_CTRL_CSLP_LO    1
`define MTD_CTRL_CSLP_HI    2
`define MTD_CTRL_VSLP_LO    3
`define MTD_CTRL_VSLP_HI    4
`define MTD_CTRL_VSEL_BIT   5
`define MTD_CTRL_RS232_BIT  6

// Command register fields (write one to act)
`define MTD_CMD_INIT_BIT    0
`define MTD_CMD_TRG_BIT     1
`define MTD_CMD_ABORT_BIT   2

// Sequence name definition fields
`define MTD_DEF_SEQ1_LO     0
`define MTD_DEF_SEQ1_HI     1
`define MTD_DEF_SEQ2_LO     8
`define MTD_DEF_SEQ2_HI     9

// ==========================================================
// Codes
`define MTD_SLOPE_EITHER    2'h0
`define MTD_SLOPE_POS       2'h1
`define MTD_SLOPE_NEG       2'h2
`define MTD_SRC_INTERNAL    1'b0
`define MTD_SRC_BUS         1'b1
`define MTD_NAME_OUTCHG     2'h1
`define MTD_NAME_MEAS       2'h2

// ==========================================================
// Reset values and limits
`define MTD_COUNT_RST       7'h01
`define MTD_COUNT_MIN       7'h01
`define MTD_COUNT_MAX       7'h64
`define MTD_RESP_OKAY       2'h0
`define MTD_RESP_SLVERR     2'h2

`endif

// ### logic/mtd_band_detector.v
/*
 File: hysteresis band crossing detector for one measured quantity.
 Assumes: samples arrive as unsigned values with a one-cycle valid strobe,
 synchronous to the clock; reset is already synchronised.
*/
`timescale 1ns/1ps
`include "mtd_defs.vh"

module mtd_band_detector #(
	parameter W = 16
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] level_i,
	input  wire [W-1:0] hyst_i,
	input  wire [1:0]   slope_i,
	input  wire         sample_valid_i,
	input  wire [W-1:0] sample_i,
	output wire         fire_o,
	output wire         rise_o,
	output wire         fall_o
);

	// ==========================================================
	// Band limits
	// One extra bit so level plus half hysteresis cannot wrap
	wire [W:0] half_w  = {1'b0, hyst_i} >> 1;
	wire [W:0] upper_w = {1'b0, level_i} + half_w;
	wire [W:0] lower_w = ({1'b0, level_i} > half_w) ? ({1'b0, level_i} - half_w) : {(W+1){1'b0}};
	wire       lo_ok_w = ({1'b0, level_i} > half_w);
	wire [W:0] smp_w   = {1'b0, sample_i};
	wire       below_w = lo_ok_w && (smp_w < lower_w);
	wire       above_w = smp_w > upper_w;

	// ==========================================================
	// Armed state: remembers which side the waveform last started from
	reg armed_lo_r;
	reg armed_hi_r;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			armed_lo_r <= 1'b0;
			armed_hi_r <= 1'b0;
		end
		else if (sample_valid_i)
		begin
			// Re-arm only after the start-side limit is passed again
			if (below_w)
				armed_lo_r <= 1'b1;
			else if (above_w)
				armed_lo_r <= 1'b0;
			if (above_w)
				armed_hi_r <= 1'b1;
			else if (below_w)
				armed_hi_r <= 1'b0;
		end
	end

	assign rise_o = sample_valid_i && armed_lo_r && above_w;
	assign fall_o = sample_valid_i && armed_hi_r && below_w;
	assign fire_o = (slope_i == `MTD_SLOPE_POS) ? rise_o :
	                (slope_i == `MTD_SLOPE_NEG) ? fall_o :
	                (rise_o | fall_o);

endmodule // mtd_band_detector

// ### logic/mtd_trigger_top.v
/*
 File: measurement trigger detector top: AXI4-Lite register slave, two
 band detectors, source selection, bus trigger and measurement count.
 Assumes: samples and bus trigger message input are synchronous to
 core_clk_i; the measurement engine pulses meas_done_i after each fire.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
// Overview of operation
// - Separate current and voltage levels, reset zero
// - Positive current trigger crosses lower then upper
// - Negative current trigger crosses upper then lower
// - Voltage positive trigger uses same band crossing
// - Negative voltage trigger crosses upper then lower
// - Per-quantity slope: rising, falling, either; default either
// - Internal source fires on crossing; reset default
// - Bus source fires on trigger command or trigger message
// - Trigger command equals group execute trigger message
// - Serial link: trigger command stands in for message
// - Sequence names fixed; query returns each alias
// - Band limits are level plus/minus half hysteresis
// - Re-wait for trigger until count measurements done
`timescale 1ns/1ps
`include "mtd_defs.vh"

module mtd_trigger_top #(
	parameter W = 16
) (
	input  wire         core_clk_i,
	input  wire         rst_n_i,
	input  wire [31:0]  s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	output wire [1:0]   s_axi_bresp,
	output wire         s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [31:0]  s_axi_araddr,
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	output wire [31:0]  s_axi_rdata,
	output wire [1:0]   s_axi_rresp,
	output wire         s_axi_rvalid,
	input  wire         s_axi_rready,
	input  wire         get_msg_i,
	input  wire         sample_valid_i,
	input  wire [W-1:0] curr_sample_i,
	input  wire [W-1:0] volt_sample_i,
	input  wire         meas_done_i,
	output wire         meas_trig_o,
	output wire         busy_o
);

	// ==========================================================
	// Reset synchroniser
	reg rst_s1_r;
	reg rst_s2_r;
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n = rst_s2_r;

	// ==========================================================
	// Registers
	reg         src_r;
	reg  [1:0]  cslope_r;
	reg  [1:0]  vslope_r;
	reg         vsel_r;
	reg         rs232_r;
	reg [W-1:0] clevel_r;
	reg [W-1:0] chyst_r;
	reg [W-1:0] vlevel_r;
	reg [W-1:0] vhyst_r;
	reg  [6:0]  count_r;
	reg  [1:0]  def1_r;
	reg  [1:0]  def2_r;
	reg         def_err_r;
	reg         cnt_err_r;

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	reg        aw_held_r;
	reg [3:0]  aw_idx_r;
	reg        w_held_r;
	reg [31:0] wdata_r;
	reg [3:0]  wstrb_r;
	reg        bvalid_r;
	reg [1:0]  bresp_r;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	wire       aw_take = s_axi_awvalid && s_axi_awready;
	wire       w_take  = s_axi_wvalid && s_axi_wready;
	wire       aw_have = aw_held_r || aw_take;
	wire       w_have  = w_held_r || w_take;
	wire [3:0] wr_idx  = aw_held_r ? aw_idx_r : s_axi_awaddr[5:2];
	wire       wr_hi0  = aw_held_r ? 1'b0 : (s_axi_awaddr[31:6] != 26'h0);
	wire [31:0] wd     = w_held_r ? wdata_r : s_axi_wdata;
	wire [3:0]  ws     = w_held_r ? wstrb_r : s_axi_wstrb;
	wire       wr_go   = aw_have && w_have && !bvalid_r;
	reg        aw_bad_r;
	wire       wr_bad  = aw_held_r ? aw_bad_r : wr_hi0;
	wire       wr_map  = !wr_bad && (wr_idx <= `MTD_OFF_SEQ_DEF) && (wr_idx != `MTD_OFF_STATUS);
	wire       wr_en   = wr_go && wr_map;
	wire       ctrl_we = wr_en && (wr_idx == `MTD_OFF_CTRL) && ws[0];
	wire       cmd_we  = wr_en && (wr_idx == `MTD_OFF_CMD) && ws[0];
	wire       init_p  = cmd_we && wd[`MTD_CMD_INIT_BIT];
	wire       trg_p   = cmd_we && wd[`MTD_CMD_TRG_BIT];
	wire       abort_p = cmd_we && wd[`MTD_CMD_ABORT_BIT];

	always @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_r <= 1'b0;
			aw_idx_r  <= 4'h0;
			aw_bad_r  <= 1'b0;
			w_held_r  <= 1'b0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `MTD_RESP_OKAY;
		end
		else
		begin
			if (wr_go)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_map ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR;
			end
			else
			begin
				if (aw_take)
				begin
					aw_held_r <= 1'b1;
					aw_idx_r  <= s_axi_awaddr[5:2];
					aw_bad_r  <= wr_hi0;
				end
				if (w_take)
				begin
					w_held_r <= 1'b1;
					wdata_r  <= s_axi_wdata;
					wstrb_r  <= s_axi_wstrb;
				end
				if (bvalid_r && s_axi_bready)
					bvalid_r <= 1'b0;
			end
		end
	end

	// Byte-lane write of a W-bit register field
	function [W-1:0] lane_wr;
		input [W-1:0] old;
		input [31:0]  d;
		input [3:0]   s;
		integer       b;
		reg   [31:0]  t;
		begin
			t = {{(32-W){1'b0}}, old};
			for (b = 0; b < 4; b = b + 1)
				if (s[b])
					t[b*8 +: 8] = d[b*8 +: 8];
			lane_wr = t[W-1:0];
		end
	endfunction

	// ==========================================================
	// Configuration registers
	wire [6:0] cnt_in   = wd[6:0];
	wire       cnt_ok   = (wd[31:7] == 25'h0) && (cnt_in >= `MTD_COUNT_MIN) && (cnt_in <= `MTD_COUNT_MAX);
	wire [1:0] def1_in  = wd[`MTD_DEF_SEQ1_HI:`MTD_DEF_SEQ1_LO];
	wire [1:0] def2_in  = wd[`MTD_DEF_SEQ2_HI:`MTD_DEF_SEQ2_LO];

	always @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_r     <= `MTD_SRC_INTERNAL;
			cslope_r  <= `MTD_SLOPE_EITHER;
			vslope_r  <= `MTD_SLOPE_EITHER;
			vsel_r    <= 1'b0;
			rs232_r   <= 1'b0;
			clevel_r  <= {W{1'b0}};
			chyst_r   <= {W{1'b0}};
			vlevel_r  <= {W{1'b0}};
			vhyst_r   <= {W{1'b0}};
			count_r   <= `MTD_COUNT_RST;
			def1_r    <= `MTD_NAME_OUTCHG;
			def2_r    <= `MTD_NAME_MEAS;
			def_err_r <= 1'b0;
			cnt_err_r <= 1'b0;
		end
		else if (wr_en)
		begin
			if (ctrl_we)
			begin
				src_r    <= wd[`MTD_CTRL_SRC_BIT];
				cslope_r <= (wd[`MTD_CTRL_CSLP_HI:`MTD_CTRL_CSLP_LO] == 2'h3) ? cslope_r :
				            wd[`MTD_CTRL_CSLP_HI:`MTD_CTRL_CSLP_LO];
				vslope_r <= (wd[`MTD_CTRL_VSLP_HI:`MTD_CTRL_VSLP_LO] == 2'h3) ? vslope_r :
				            wd[`MTD_CTRL_VSLP_HI:`MTD_CTRL_VSLP_LO];
				vsel_r   <= wd[`MTD_CTRL_VSEL_BIT];
				rs232_r  <= wd[`MTD_CTRL_RS232_BIT];
			end
			if (wr_idx == `MTD_OFF_CURR_LEVEL)
				clevel_r <= lane_wr(clevel_r, wd, ws);
			if (wr_idx == `MTD_OFF_CURR_HYST)
				chyst_r <= lane_wr(chyst_r, wd, ws);
			if (wr_idx == `MTD_OFF_VOLT_LEVEL)
				vlevel_r <= lane_wr(vlevel_r, wd, ws);
			if (wr_idx == `MTD_OFF_VOLT_HYST)
				vhyst_r <= lane_wr(vhyst_r, wd, ws);
			if (wr_idx == `MTD_OFF_COUNT && ws[0])
			begin
				// Out-of-range counts are refused and flagged
				if (cnt_ok)
					count_r <= cnt_in;
				cnt_err_r <= !cnt_ok;
			end
			if (wr_idx == `MTD_OFF_SEQ_DEF && ws[1:0] == 2'h3)
			begin
				// Only the fixed names are accepted per sequence
				def_err_r <= (def1_in != `MTD_NAME_OUTCHG) || (def2_in != `MTD_NAME_MEAS);
			end
		end
	end

	// ==========================================================
	// Band detectors
	wire c_fire;
	wire v_fire;
	wire c_rise;
	wire c_fall;
	wire v_rise;
	wire v_fall;

	mtd_band_detector #(.W(W)) u_curr (
		.clk_i          (core_clk_i),
		.rst_n_i        (rst_n),
		.level_i        (clevel_r),
		.hyst_i         (chyst_r),
		.slope_i        (cslope_r),
		.sample_valid_i (sample_valid_i),
		.sample_i       (curr_sample_i),
		.fire_o         (c_fire),
		.rise_o         (c_rise),
		.fall_o         (c_fall)
	);

	mtd_band_detector #(.W(W)) u_volt (
		.clk_i          (core_clk_i),
		.rst_n_i        (rst_n),
		.level_i        (vlevel_r),
		.hyst_i         (vhyst_r),
		.slope_i        (vslope_r),
		.sample_valid_i (sample_valid_i),
		.sample_i       (volt_sample_i),
		.fire_o         (v_fire),
		.rise_o         (v_rise),
		.fall_o         (v_fall)
	);

	// ==========================================================
	// Trigger source and measurement sequence
	// The serial link has no interface message, so only the command fires there
	wire bus_evt = trg_p || (get_msg_i && !rs232_r);
	wire int_evt = vsel_r ? v_fire : c_fire;
	wire trig_ev = (src_r == `MTD_SRC_BUS) ? bus_evt : int_evt;

	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_MEAS = 3'b100;

	reg [2:0] state_r;
	reg [6:0] done_r;
	reg       trig_r;

	always @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			done_r  <= 7'h0;
			trig_r  <= 1'b0;
		end
		else
		begin
			trig_r <= 1'b0;
			if (abort_p)
				state_r <= ST_IDLE;
			else
			begin
				case (state_r)
				ST_IDLE:
					if (init_p)
					begin
						state_r <= ST_WAIT;
						done_r  <= 7'h0;
					end
				ST_WAIT:
					if (trig_ev)
					begin
						trig_r  <= 1'b1;
						state_r <= ST_MEAS;
					end
				ST_MEAS:
					if (meas_done_i)
					begin
						// Wait again for a fresh trigger until the count is met
						done_r  <= done_r + 7'h01;
						state_r <= (done_r + 7'h01 >= count_r) ? ST_IDLE : ST_WAIT;
					end
				default:
					state_r <= ST_IDLE;
				endcase
			end
		end
	end

	assign meas_trig_o = trig_r;
	assign busy_o      = !state_r[0];

	// ==========================================================
	// Read channel
	reg        rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0]  rresp_r;
	reg [31:0] rd_w;
	reg        rd_ok;
	wire [3:0] rd_idx = s_axi_araddr[5:2];

	always @*
	begin
		rd_w  = 32'h0;
		rd_ok = (s_axi_araddr[31:6] == 26'h0);
		case (rd_idx)
		`MTD_OFF_CTRL:       rd_w = {25'h0, rs232_r, vsel_r, vslope_r, cslope_r, src_r};
		`MTD_OFF_CURR_LEVEL: rd_w = {{(32-W){1'b0}}, clevel_r};
		`MTD_OFF_CURR_HYST:  rd_w = {{(32-W){1'b0}}, chyst_r};
		`MTD_OFF_VOLT_LEVEL: rd_w = {{(32-W){1'b0}}, vlevel_r};
		`MTD_OFF_VOLT_HYST:  rd_w = {{(32-W){1'b0}}, vhyst_r};
		`MTD_OFF_COUNT:      rd_w = {25'h0, count_r};
		`MTD_OFF_STATUS:     rd_w = {13'h0, done_r, 4'h0, v_fall, v_rise, c_fall, c_rise,
		                             cnt_err_r, def_err_r, busy_o, state_r[1]};
		`MTD_OFF_CMD:        rd_w = 32'h0;
		`MTD_OFF_SEQ_DEF:    rd_w = {22'h0, def2_r, 6'h0, def1_r};
		default:             rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= `MTD_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_ok ? rd_w : 32'h0;
			rresp_r  <= rd_ok ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end

endmodule // mtd_trigger_top

// ### dv/mtd_meas_model.sv
/*
 Measurement engine stand-in: one done pulse per trigger, counts triggers.
 Assumes the trigger is a one-cycle pulse on the shared clock.
*/
`timescale 1ns/1ps

module mtd_meas_model (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       trig_i,
	output reg        done_o,
	output reg  [7:0] trig_cnt_o
);
	reg [3:0] wait_r;
	reg       slow_r;

	// ========
	// Answer
	// Alternates a quick and a slow answer so both timings get exercised
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{done_o, slow_r, wait_r, trig_cnt_o} <= 14'h0000;
		end
		else
		begin
			done_o <= (wait_r == 4'h1);
			if (trig_i)
			begin
				trig_cnt_o <= trig_cnt_o + 8'h01;
				wait_r     <= slow_r ? 4'h6 : 4'h1;
				slow_r     <= ~slow_r;
			end
			else if (wait_r != 4'h0)
				wait_r <= wait_r - 4'h1;
		end
	end
endmodule // mtd_meas_model

// ### dv/mtd_trigger_chk.sv
/*
 Checker on the trigger detector top ports.
 Assumes the master offers write address and data together.
*/
`timescale 1ns/1ps

module mtd_trigger_chk (
	input wire        core_clk_i,
	input wire        rst_n_i,
	input wire [31:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        get_msg_i,
	input wire        sample_valid_i,
	input wire        meas_done_i,
	input wire        meas_trig_o,
	input wire        busy_o
);
	// ========
	// Shadow of source bits and the measurement in flight
	wire wr_ok = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
	wire cmd_trg = wr_ok & (s_axi_awaddr == 32'h0000001c) & s_axi_wdata[1];
	reg  src_r;
	reg  ser_r;
	reg  pend_r;

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{src_r, ser_r, pend_r} <= 3'h0;
		else
		begin
			if (wr_ok && s_axi_awaddr == 32'h00000000)
				{ser_r, src_r} <= {s_axi_wdata[6], s_axi_wdata[0]};
			pend_r <= meas_trig_o | (pend_r & ~meas_done_i);
		end
	end

	// ========
	// Properties
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_msg;
		src_r && !ser_r && get_msg_i && busy_o && !pend_r && !meas_trig_o;
	endsequence
	sequence s_cmd;
		src_r && cmd_trg && busy_o && !pend_r && !meas_trig_o;
	endsequence
	property p_trig_one;
		meas_trig_o |=> !meas_trig_o;
	endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger pulse too long");
	property p_trig_busy;
		meas_trig_o |-> busy_o;
	endproperty
	a_trig_busy: assert property (p_trig_busy) else $error("trigger while idle");
	property p_trig_once;
		meas_trig_o |-> !pend_r;
	endproperty
	a_trig_once: assert property (p_trig_once) else $error("trigger before done");
	property p_idle_quiet;
		!busy_o |=> !meas_trig_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("trigger after idle");
	property p_int_cause;
		!src_r && meas_trig_o |-> $past(sample_valid_i);
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("internal trigger without sample");
	property p_bus_cause;
		src_r && meas_trig_o |-> $past(cmd_trg || get_msg_i && !ser_r);
	endproperty
	a_bus_cause: assert property (p_bus_cause) else $error("bus trigger without cause");
	property p_msg_fire;
		s_msg |=> meas_trig_o;
	endproperty
	a_msg_fire: assert property (p_msg_fire) else $error("message did not trigger");
	property p_cmd_fire;
		s_cmd |=> meas_trig_o;
	endproperty
	a_cmd_fire: assert property (p_cmd_fire) else $error("command did not trigger");
endmodule // mtd_trigger_chk

bind mtd_trigger_top mtd_trigger_chk u_chk (.core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .get_msg_i,
	.sample_valid_i, .meas_done_i, .meas_trig_o, .busy_o);

// ### dv/test_measurement_trigger_detector.sv
/*
 Bench: register calls, samples and bus messages against trigger counts.
 Assumes the engine stand-in answers every trigger.
*/
`timescale 1ns/1ps

module test_measurement_trigger_detector;
	logic        core_clk_i, rst_n_i;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        get_msg_i, sample_valid_i, meas_done_i, meas_trig_o, busy_o;
	logic [15:0] curr_sample_i, volt_sample_i;
	logic [7:0]  tc;
	integer      failures, comparisons;

	mtd_trigger_top #(.W(16)) DUT (.core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .get_msg_i, .sample_valid_i, .curr_sample_i, .volt_sample_i,
		.meas_done_i, .meas_trig_o, .busy_o);
	mtd_meas_model u_eng (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .trig_i(meas_trig_o),
		.done_o(meas_done_i), .trig_cnt_o(tc));

	// ========
	// Tasks
	task results;
		begin
			$display("comparisons %0d failures %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	task chk(input [31:0] s, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e)
			begin
				failures = failures + 1;
				$display("[ERR] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask

	task gap;
		repeat (10) @(posedge core_clk_i);
	endtask

	// A response of 3 is never produced, so it marks an unchecked one
	task acc(input w, input [31:0] a, input [31:0] d, input [31:0] e, input [1:0] er);
		reg        fin, ah, dh;
		reg [1:0]  rs;
		reg [31:0] rd;
		begin
			fin = 1'b0;
			if (w)
				{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
			else
				{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
			while (!fin)
			begin
				@(negedge core_clk_i);
				ah = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
				dh = s_axi_wvalid & s_axi_wready;
				fin = w ? s_axi_bvalid : s_axi_rvalid;
				rs = w ? s_axi_bresp : s_axi_rresp;
				rd = s_axi_rdata;
				@(posedge core_clk_i);
				if (ah)
					{s_axi_awvalid, s_axi_arvalid} <= 2'h0;
				if (dh)
					s_axi_wvalid <= 1'b0;
			end
			{s_axi_bready, s_axi_rready} <= 2'h0;
			@(posedge core_clk_i);
			if (er != 2'h3)
				chk(rs, er);
			if (!w)
				chk(rd, e);
		end
	endtask

	task smp(input [15:0] c, input [15:0] v);
		begin
			{curr_sample_i, volt_sample_i, sample_valid_i} <= {c, v, 1'b1};
			@(posedge core_clk_i);
			sample_valid_i <= 1'b0;
			gap;
		end
	endtask

	task msg;
		begin
			get_msg_i <= 1'b1;
			@(posedge core_clk_i);
			get_msg_i <= 1'b0;
			gap;
		end
	endtask

	// ========
	// Clock, watchdog, sequence
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		#40000;
		failures = failures + 1;
		results;
	end

	initial
	begin
		{failures, comparisons, rst_n_i} = 0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, get_msg_i, sample_valid_i, curr_sample_i, volt_sample_i} = 0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		acc(0, 8'h00, 0, 0, 2'h0);
		acc(0, 8'h04, 0, 0, 2'h0);
		acc(0, 8'h0c, 0, 0, 2'h0);
		acc(0, 8'h14, 0, 1, 2'h0);
		acc(0, 8'h20, 0, 16'h0201, 2'h0);
		acc(1, 8'h04, 16'h0100, 0, 2'h0);
		acc(1, 8'h08, 16'h0020, 0, 2'h0);
		acc(1, 8'h14, 2, 0, 2'h0);
		smp(16'h00ef, 0);
		acc(1, 8'h1c, 1, 0, 2'h0);
		chk(busy_o, 1);
		msg;
		chk(tc, 0);
		smp(16'h0110, 0);
		chk(tc, 0);
		smp(16'h0111, 0);
		chk(tc, 1);
		smp(16'h0200, 0);
		chk(tc, 1);
		smp(16'h00f0, 0);
		chk(tc, 1);
		smp(16'h00ef, 0);
		chk(tc, 2);
		chk(busy_o, 0);
		acc(1, 8'h00, 2, 0, 2'h0);
		acc(1, 8'h1c, 1, 0, 2'h0);
		smp(16'h0111, 0);
		smp(16'h00ef, 0);
		chk(tc, 3);
		smp(16'h0111, 0);
		chk(tc, 4);
		acc(1, 8'h0c, 16'h0080, 0, 2'h0);
		acc(1, 8'h10, 16'h0010, 0, 2'h0);
		acc(1, 8'h14, 1, 0, 2'h0);
		acc(1, 8'h00, 8'h30, 0, 2'h0);
		smp(16'h0100, 16'h0077);
		acc(1, 8'h1c, 1, 0, 2'h0);
		smp(16'h0100, 16'h0089);
		smp(16'h0100, 16'h0078);
		chk(tc, 4);
		smp(16'h0100, 16'h0077);
		chk(tc, 5);
		acc(1, 8'h00, 8'h28, 0, 2'h0);
		acc(1, 8'h1c, 1, 0, 2'h0);
		smp(16'h0100, 16'h0089);
		chk(tc, 6);
		acc(1, 8'h00, 1, 0, 2'h0);
		acc(1, 8'h14, 3, 0, 2'h0);
		acc(1, 8'h1c, 1, 0, 2'h0);
		smp(16'h00ef, 16'h0077);
		smp(16'h0111, 16'h0089);
		chk(tc, 6);
		msg;
		chk(tc, 7);
		acc(1, 8'h1c, 2, 0, 2'h0);
		gap;
		chk(tc, 8);
		acc(1, 8'h00, 8'h41, 0, 2'h0);
		msg;
		chk(tc, 8);
		acc(1, 8'h1c, 2, 0, 2'h0);
		gap;
		chk(tc, 9);
		chk(busy_o, 0);
		acc(1, 8'h14, 0, 0, 2'h0);
		acc(0, 8'h14, 0, 3, 2'h0);
		acc(1, 8'h14, 8'h64, 0, 2'h0);
		acc(1, 8'h14, 8'h65, 0, 2'h0);
		acc(0, 8'h18, 0, 32'h00003008, 2'h0);
		acc(0, 8'h14, 0, 8'h64, 2'h0);
		acc(1, 8'h20, 16'h0102, 0, 2'h0);
		acc(0, 8'h20, 0, 16'h0201, 2'h0);
		acc(0, 8'h18, 0, 32'h0000300c, 2'h0);
		acc(1, 8'h04, 16'hffff, 0, 2'h0);
		acc(0, 8'h04, 0, 16'hffff, 2'h0);
		acc(0, 8'h0c, 0, 16'h0080, 2'h0);
		acc(1, 8'h1c, 1, 0, 2'h0);
		chk(busy_o, 1);
		acc(0, 8'h18, 0, 32'h0000000f, 2'h0);
		acc(1, 8'h1c, 4, 0, 2'h0);
		chk(busy_o, 0);
		acc(0, 8'h24, 0, 0, 2'h2);
		acc(1, 8'h18, 0, 0, 2'h2);
		results;
	end
endmodule // test_measurement_trigger_detector
